// file: src/xrs_pkg.sv
// Purpose: Constants and types of the transfer request front end.
// Assumes: One core clock, 32-bit IO registers.
// Notes:   Offsets are byte addresses in the IO window.
package xrs_pkg;
   // Register offsets.
   localparam logic [11:0] XRS_OFF_EBASE = 12'h110;
   localparam logic [11:0] XRS_OFF_LADDR = 12'h114;
   localparam logic [11:0] XRS_OFF_CTRL  = 12'h118;
   localparam logic [11:0] XRS_OFF_EOFF  = 12'h11c;
   localparam logic [11:0] XRS_OFF_STAT  = 12'h120;
   // Control register fields.
   localparam int XRS_CTL_PEND = 0;
   localparam int XRS_CTL_UNK  = 1;
   localparam int XRS_CTL_SEC  = 2;
   localparam int XRS_CTL_MODE = 4;
   localparam int XRS_CTL_SIZE = 8;
   localparam int XRS_CTL_PORT = 12;
   // Status register fields.
   localparam int XRS_ST_BUSY = 1;
   localparam int XRS_ST_RW   = 4;
   localparam int XRS_ST_NDST = 16;
   localparam int XRS_ST_NDLD = 24;
   // Port target special register fields.
   localparam int XRS_TG_CODE = 0;
   localparam int XRS_TG_DLD  = 8;
   localparam int XRS_TG_DST  = 12;
   // Operand and authorization fields.
   localparam int XRS_OP_SIZE = 16;
   localparam int XRS_AUTH_SEC = 16;
   localparam int XRS_EBASE_SH = 8;
   // Transfer modes as coded in the control register.
   localparam logic [1:0] XRS_M_DLD = 2'h0;
   localparam logic [1:0] XRS_M_CLD = 2'h1;
   localparam logic [1:0] XRS_M_DST = 2'h2;
   // Instruction subopcodes.
   localparam logic [3:0] XRS_OP_DWAIT = 4'h3;
   localparam logic [3:0] XRS_OP_CLD   = 4'h4;
   localparam logic [3:0] XRS_OP_DLD   = 4'h5;
   localparam logic [3:0] XRS_OP_DST   = 4'h6;
   localparam logic [3:0] XRS_OP_CWAIT = 4'h7;
   // Special register selects.
   localparam logic [1:0] XRS_SR_DBASE = 2'h0;
   localparam logic [1:0] XRS_SR_CBASE = 2'h1;
   localparam logic [1:0] XRS_SR_TGTS  = 2'h2;
   // Sizes, queue depth and per-class counter limit.
   localparam logic [8:0] XRS_WORD_BYTES = 9'h004;
   localparam logic [8:0] XRS_PAGE_BYTES = 9'h100;
   localparam int XRS_QDEPTH = 4;
   localparam logic [2:0] XRS_CNT_MAX = 3'h7;
   // One queued request.
   typedef struct packed {
      logic [1:0]  mode;
      logic [2:0]  port;
      logic [2:0]  size;
      logic        sec;
      logic [31:0] addr;
      logic [15:0] local_a;
   } xrs_entry_s;
endpackage

// file: src/xrs_front.sv
// Purpose: Takes transfer requests from core instructions and IO writes,
//          queues them and hands them to the memory port.
// Assumes: Memory port echoes mode, page and secret flag on completion.
// Notes:   Notes on behaviour
`timescale 1ns/10ps
module xrs_front
   import xrs_pkg::*;
(
   // Clock and reset.
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   // IO register port.
   input  wire logic        io_wr,
   input  wire logic        io_rd,
   input  wire logic [11:0] io_addr,
   input  wire logic [31:0] io_wdata,
   output logic [31:0]      io_rdata_r,
   output logic             io_rvalid_r,
   // Core special registers and instructions.
   input  wire logic        sr_wr,
   input  wire logic [1:0]  sr_sel,
   input  wire logic [31:0] sr_wdata,
   input  wire logic [31:0] cauth,
   input  wire logic        ins_valid,
   input  wire logic [3:0]  ins_subop,
   input  wire logic [31:0] ins_src1,
   input  wire logic [31:0] ins_src2,
   output logic             ins_done_r,
   // Memory port requests.
   output logic             xfer_valid_r,
   input  wire logic        xfer_ready,
   output logic [1:0]       xfer_mode_r,
   output logic [2:0]       xfer_port_r,
   output logic [31:0]      xfer_addr_r,
   output logic [15:0]      xfer_local_r,
   output logic [8:0]       xfer_bytes_r,
   output logic             xfer_secret_r,
   // Memory port completions.
   input  wire logic        done_valid,
   input  wire logic [1:0]  done_mode,
   input  wire logic [7:0]  done_page,
   input  wire logic        done_secret,
   // Code page state updates.
   output logic             page_busy_r,
   output logic [7:0]       page_busy_idx_r,
   output logic             page_rel_r,
   output logic [7:0]       page_rel_idx_r,
   output logic             page_rel_secret_r
);

   // Whole state of the block.
   typedef struct packed {
      logic [31:0] ebase;
      logic [31:0] laddr;
      logic [31:0] eoff;
      logic [31:0] ctrl;
      logic [1:0]  st_rw;
      logic [31:0] dbase;
      logic [31:0] cbase;
      logic [31:0] tgts;
      xrs_entry_s [XRS_QDEPTH-1:0] q;
      logic [1:0]  head;
      logic [2:0]  cnt;
      logic [2:0]  n_cld;
      logic [2:0]  n_dld;
      logic [2:0]  n_dst;
      xrs_entry_s  o;
      logic [8:0]  obytes;
      logic        ov;
      logic        ins_done;
      logic [31:0] rdata;
      logic        rvalid;
      logic        pbusy;
      logic [7:0]  pbusy_idx;
      logic        prel;
      logic [7:0]  prel_idx;
      logic        prel_sec;
   } xrs_state_s;

   xrs_state_s s_r;   // Registered state.
   xrs_state_s s_nxt; // Next state.

   // External address of a request from its base and offset.
   function automatic logic [31:0] xrs_addr(input logic [31:0] b,
                                            input logic [31:0] o);
      xrs_addr = (b << XRS_EBASE_SH) + o;
   endfunction

   // Byte count of a request.
   function automatic logic [8:0] xrs_bytes(input logic [1:0] m,
                                            input logic [2:0] sz);
      xrs_bytes = (m == XRS_M_CLD) ? XRS_PAGE_BYTES
                                   : 9'(XRS_WORD_BYTES << sz);
   endfunction

   // Class counter of a mode.
   function automatic logic [2:0] xrs_ncls(input xrs_state_s st,
                                           input logic [1:0] m);
      unique case (m)
         XRS_M_CLD: xrs_ncls = st.n_cld;
         XRS_M_DST: xrs_ncls = st.n_dst;
         default:   xrs_ncls = st.n_dld;
      endcase
   endfunction

   // Decoded instruction and candidate requests.
   logic       ins_sub;  // Submission instruction present.
   logic       ins_wait; // Wait instruction present.
   logic       ins_idle; // Class waited on has drained.
   xrs_entry_s e_ins;    // Request built from the instruction.
   xrs_entry_s e_ctl;    // Request built from the IO registers.
   xrs_entry_s e_new;    // Request actually queued.
   logic       enq;      // A request enters the queue.
   logic       deq;      // Queue head moves to the output stage.
   logic       take;     // Instruction completes this cycle.

   // Decode instructions and build both candidate requests.
   always_comb begin
      ins_sub  = ins_valid && !s_r.ins_done &&
                 (ins_subop == XRS_OP_CLD || ins_subop == XRS_OP_DLD ||
                  ins_subop == XRS_OP_DST);
      ins_wait = ins_valid && !s_r.ins_done &&
                 (ins_subop == XRS_OP_CWAIT || ins_subop == XRS_OP_DWAIT);
      ins_idle = (ins_subop == XRS_OP_CWAIT) ? (s_r.n_cld == 3'h0)
               : (s_r.n_dld == 3'h0 && s_r.n_dst == 3'h0);
      e_ins.local_a = ins_src2[15:0];
      e_ins.size    = ins_src2[XRS_OP_SIZE +: 3];
      e_ins.sec     = 1'b0;
      unique case (ins_subop)
         XRS_OP_CLD: begin
            e_ins.mode = XRS_M_CLD;
            e_ins.port = s_r.tgts[XRS_TG_CODE +: 3];
            e_ins.addr = xrs_addr(s_r.cbase, ins_src1);
            e_ins.sec  = cauth[XRS_AUTH_SEC];
         end
         XRS_OP_DST: begin
            e_ins.mode = XRS_M_DST;
            e_ins.port = s_r.tgts[XRS_TG_DST +: 3];
            e_ins.addr = xrs_addr(s_r.dbase, ins_src1);
         end
         default: begin
            e_ins.mode = XRS_M_DLD;
            e_ins.port = s_r.tgts[XRS_TG_DLD +: 3];
            e_ins.addr = xrs_addr(s_r.dbase, ins_src1);
         end
      endcase
      e_ctl.addr    = xrs_addr(s_r.ebase, s_r.eoff);
      e_ctl.local_a = s_r.laddr[15:0];
      e_ctl.mode = s_r.ctrl[XRS_CTL_MODE +: 2];
      e_ctl.size = s_r.ctrl[XRS_CTL_SIZE +: 3];
      e_ctl.port = s_r.ctrl[XRS_CTL_PORT +: 3];
      e_ctl.sec  = s_r.ctrl[XRS_CTL_SEC];
   end

   // Queue, counters, register file and outputs.
   always_comb begin
      s_nxt = s_r;
      // Instructions take priority over a pending control launch.
      e_new = ins_sub ? e_ins : e_ctl;
      enq = (ins_sub || s_r.ctrl[XRS_CTL_PEND]) &&
            (s_r.cnt < 3'(XRS_QDEPTH)) &&
            (xrs_ncls(s_r, e_new.mode) != XRS_CNT_MAX);
      take = (ins_sub && enq) || (ins_wait && ins_idle);
      s_nxt.ins_done = take;
      deq = (s_r.cnt != 3'h0) && (!s_r.ov || xfer_ready);
      // The output stage drops its request once the port takes it.
      if (s_r.ov && xfer_ready) begin
         s_nxt.ov = 1'b0;
      end
      if (deq) begin
         s_nxt.o    = s_r.q[s_r.head];
         // Byte count is registered so the output comes from a flip-flop.
         s_nxt.obytes = xrs_bytes(s_r.q[s_r.head].mode, s_r.q[s_r.head].size);
         s_nxt.ov   = 1'b1;
         s_nxt.head = s_r.head + 2'h1;
      end
      if (enq) begin
         s_nxt.q[s_r.head + s_r.cnt[1:0]] = e_new;
      end
      s_nxt.cnt = s_r.cnt + {2'h0, enq} - {2'h0, deq};
      if (enq && !ins_sub) begin
         s_nxt.ctrl[XRS_CTL_PEND] = 1'b0;
      end
      s_nxt.n_cld = s_r.n_cld
         + {2'h0, enq && e_new.mode == XRS_M_CLD}
         - {2'h0, done_valid && done_mode == XRS_M_CLD};
      s_nxt.n_dld = s_r.n_dld
         + {2'h0, enq && e_new.mode == XRS_M_DLD}
         - {2'h0, done_valid && done_mode == XRS_M_DLD};
      s_nxt.n_dst = s_r.n_dst
         + {2'h0, enq && e_new.mode == XRS_M_DST}
         - {2'h0, done_valid && done_mode == XRS_M_DST};
      s_nxt.pbusy     = enq && e_new.mode == XRS_M_CLD;
      s_nxt.pbusy_idx = e_new.local_a[15:8];
      s_nxt.prel      = done_valid && done_mode == XRS_M_CLD;
      s_nxt.prel_idx  = done_page;
      s_nxt.prel_sec  = done_secret;
      // Core writes to its special registers.
      if (sr_wr) begin
         unique case (sr_sel)
            XRS_SR_DBASE: s_nxt.dbase = sr_wdata;
            XRS_SR_CBASE: s_nxt.cbase = sr_wdata;
            XRS_SR_TGTS:  s_nxt.tgts  = sr_wdata;
            default:      s_nxt.tgts  = s_r.tgts;
         endcase
      end
      // IO register writes.
      if (io_wr) begin
         unique case (io_addr)
            XRS_OFF_EBASE: s_nxt.ebase = io_wdata;
            XRS_OFF_LADDR: s_nxt.laddr = io_wdata;
            XRS_OFF_EOFF:  s_nxt.eoff  = io_wdata;
            XRS_OFF_STAT:  s_nxt.st_rw = io_wdata[XRS_ST_RW +: 2];
            XRS_OFF_CTRL: begin
               s_nxt.ctrl = io_wdata;
               s_nxt.ctrl[XRS_CTL_UNK]  = 1'b0;
               s_nxt.ctrl[XRS_CTL_PEND] = 1'b1;
            end
            default: s_nxt.ctrl = s_nxt.ctrl;
         endcase
      end
      // IO register reads answer one cycle later; unmapped reads give 0.
      s_nxt.rvalid = io_rd;
      s_nxt.rdata  = 32'h0;
      unique case (io_addr)
         XRS_OFF_EBASE: s_nxt.rdata = s_r.ebase;
         XRS_OFF_LADDR: s_nxt.rdata = s_r.laddr;
         XRS_OFF_EOFF:  s_nxt.rdata = s_r.eoff;
         XRS_OFF_CTRL:  s_nxt.rdata = s_r.ctrl;
         XRS_OFF_STAT: begin
            s_nxt.rdata[XRS_ST_BUSY] = (s_r.n_dld != 3'h0) ||
                                       (s_r.n_dst != 3'h0);
            s_nxt.rdata[XRS_ST_RW +: 2]   = s_r.st_rw;
            s_nxt.rdata[XRS_ST_NDST +: 3] = s_r.n_dst;
            s_nxt.rdata[XRS_ST_NDLD +: 3] = s_r.n_dld;
         end
         default: s_nxt.rdata = 32'h0;
      endcase
      if (sys_rst) begin
         s_nxt = '0;
      end
   end

   // State register.
   always_ff @(posedge sys_clk) begin
      s_r <= s_nxt;
   end

   // Outputs come straight from state flip-flops.
   assign io_rdata_r        = s_r.rdata;
   assign io_rvalid_r       = s_r.rvalid;
   assign ins_done_r        = s_r.ins_done;
   assign xfer_valid_r      = s_r.ov;
   assign xfer_mode_r       = s_r.o.mode;
   assign xfer_port_r       = s_r.o.port;
   assign xfer_addr_r       = s_r.o.addr;
   assign xfer_local_r      = s_r.o.local_a;
   assign xfer_bytes_r      = s_r.obytes;
   assign xfer_secret_r     = s_r.o.sec;
   assign page_busy_r       = s_r.pbusy;
   assign page_busy_idx_r   = s_r.pbusy_idx;
   assign page_rel_r        = s_r.prel;
   assign page_rel_idx_r    = s_r.prel_idx;
   assign page_rel_secret_r = s_r.prel_sec;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   // A write to the control register.
   sequence ctl_write_s;
      io_wr && io_addr == XRS_OFF_CTRL;
   endsequence

   ctl_pend_a: assert property (
      ctl_write_s |=> s_r.ctrl[XRS_CTL_PEND])
      else $error("pending bit not set by control write");
   ctl_read_a: assert property (
      io_rd && io_addr == XRS_OFF_CTRL |=> io_rvalid_r &&
      io_rdata_r == $past(s_r.ctrl))
      else $error("control read-back wrong");
   stat_busy_a: assert property (
      io_rd && io_addr == XRS_OFF_STAT && s_r.n_dld != 3'h0
      |=> io_rdata_r[XRS_ST_BUSY])
      else $error("busy bit low with loads pending");
   stat_cnt_a: assert property (
      io_rd && io_addr == XRS_OFF_STAT |=>
      io_rdata_r[XRS_ST_NDST +: 3] == $past(s_r.n_dst))
      else $error("store count wrong");
   cwait_rel_a: assert property (
      ins_done_r && $past(ins_subop) == XRS_OP_CWAIT
      |-> $past(s_r.n_cld) == 3'h0)
      else $error("code wait released early");
   cld_busy_a: assert property (
      ins_sub && enq && ins_subop == XRS_OP_CLD
      |=> page_busy_r && page_busy_idx_r == $past(ins_src2[15:8]))
      else $error("code page not marked busy");
   cld_sec_a: assert property (
      ins_sub && enq && ins_subop == XRS_OP_CLD
      |=> s_r.q[$past(s_r.head + s_r.cnt[1:0])].sec
          == $past(cauth[XRS_AUTH_SEC]))
      else $error("code load secret flag wrong");
   bytes_a: assert property (
      xfer_valid_r && xfer_mode_r == XRS_M_CLD |-> xfer_bytes_r == 9'h100)
      else $error("code transfer not a page");
   hold_a: assert property (
      xfer_valid_r && !xfer_ready |=> xfer_valid_r && $stable(xfer_addr_r))
      else $error("request dropped before taken");
   dcount_a: assert property (
      enq && e_new.mode == XRS_M_DST && !done_valid
      |=> s_r.n_dst == $past(s_r.n_dst) + 3'h1 && $stable(s_r.n_cld))
      else $error("store counter not incremented");
endmodule

// file: tb/xrs_mem_model.sv
// Purpose: Memory port model that takes requests and reports completions.
// Assumes: Requests complete one at a time, in the order they were taken.
// Notes:   Stall holds ready low and withholds every completion.
`timescale 1ns/10ps
module xrs_mem_model
   import xrs_pkg::*;
#(
   parameter int DLY = 3
)
(
   // Clock and reset.
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   // Test control.
   input  wire logic        stall,
   // Request side.
   input  wire logic        xfer_valid,
   input  wire logic [1:0]  xfer_mode,
   input  wire logic [15:0] xfer_local,
   input  wire logic        xfer_secret,
   output logic             xfer_ready,
   // Completion side.
   output logic             done_valid,
   output logic [1:0]       done_mode,
   output logic [7:0]       done_page,
   output logic             done_secret
);
   // Taken requests awaiting completion: mode, page and secret flag.
   logic [10:0] pend_q[$];
   // Cycles left before the next completion may be reported.
   int          wait_cnt;
   // Request being completed.
   logic [10:0] head;

   // delayed completions
   // Completions trail the requests, so the queue really fills up.
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         xfer_ready <= 1'b0;
         done_valid <= 1'b0;
         {done_mode, done_page, done_secret} <= 11'h000;
         wait_cnt <= 0;
         pend_q.delete();
      end else begin
         xfer_ready <= !stall;
         // A request is taken on an edge where valid meets ready.
         if (xfer_valid === 1'b1 && xfer_ready) begin
            pend_q.push_back({xfer_mode, xfer_local[15:8], xfer_secret});
         end
         if (!stall && pend_q.size() > 0 && wait_cnt == 0) begin
            head = pend_q.pop_front();
            {done_mode, done_page, done_secret} <= head;
            done_valid <= 1'b1;
            wait_cnt <= DLY;
         end else begin
            // Idle fields flip so that stale values are never trusted.
            {done_mode, done_page, done_secret} <=
               ~{done_mode, done_page, done_secret};
            done_valid <= 1'b0;
            if (wait_cnt > 0) begin
               wait_cnt <= wait_cnt - 1;
            end
         end
      end
   end
endmodule

// file: tb/testbench.sv
// Purpose: Self-checking bench of the transfer request front end.
// Assumes: Inputs change at the falling edge of the clock.
// Notes:   A stalled memory port keeps requests queued for inspection.
`timescale 1ns/10ps
module testbench import xrs_pkg::*;;
   // Design and model connections.
   logic        sys_clk, sys_rst, io_wr, io_rd, sr_wr, ins_valid, stall;
   logic [11:0] io_addr;
   logic [31:0] io_wdata, io_rdata_r, sr_wdata, cauth, ins_src1, ins_src2;
   logic [31:0] xfer_addr_r;
   logic [1:0]  sr_sel, xfer_mode_r, done_mode;
   logic [3:0]  ins_subop;
   logic [2:0]  xfer_port_r;
   logic [15:0] xfer_local_r;
   logic [8:0]  xfer_bytes_r;
   logic [7:0]  done_page, page_busy_idx_r, page_rel_idx_r;
   logic        io_rvalid_r, ins_done_r, xfer_valid_r, xfer_ready;
   logic        xfer_secret_r, done_valid, done_secret, page_busy_r;
   logic        page_rel_r, page_rel_secret_r, rel_sec;
   // Observed requests, page events and counters.
   xrs_entry_s  obs_q[$];
   logic [8:0]  obs_b[$];
   logic [7:0]  busy_idx, rel_idx;
   int          mismatches, samples_checked, done_cnt, cyc;

   xrs_front xrs_front_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr), .io_wdata(io_wdata),
      .io_rdata_r(io_rdata_r), .io_rvalid_r(io_rvalid_r), .sr_wr(sr_wr),
      .sr_sel(sr_sel), .sr_wdata(sr_wdata), .cauth(cauth),
      .ins_valid(ins_valid), .ins_subop(ins_subop), .ins_src1(ins_src1),
      .ins_src2(ins_src2), .ins_done_r(ins_done_r),
      .xfer_valid_r(xfer_valid_r), .xfer_ready(xfer_ready),
      .xfer_mode_r(xfer_mode_r), .xfer_port_r(xfer_port_r),
      .xfer_addr_r(xfer_addr_r), .xfer_local_r(xfer_local_r),
      .xfer_bytes_r(xfer_bytes_r), .xfer_secret_r(xfer_secret_r),
      .done_valid(done_valid), .done_mode(done_mode),
      .done_page(done_page), .done_secret(done_secret),
      .page_busy_r(page_busy_r), .page_busy_idx_r(page_busy_idx_r),
      .page_rel_r(page_rel_r), .page_rel_idx_r(page_rel_idx_r),
      .page_rel_secret_r(page_rel_secret_r));

   xrs_mem_model xrs_mem_model_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .stall(stall), .xfer_valid(xfer_valid_r), .xfer_mode(xfer_mode_r),
      .xfer_local(xfer_local_r), .xfer_secret(xfer_secret_r),
      .xfer_ready(xfer_ready), .done_valid(done_valid),
      .done_mode(done_mode), .done_page(done_page),
      .done_secret(done_secret));

   // Clock of 4 ns period.
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   // Records handshakes and page events, and cuts a hang short.
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (!sys_rst && xfer_valid_r === 1'b1 && xfer_ready === 1'b1) begin
         obs_q.push_back({xfer_mode_r, xfer_port_r, 3'h0, xfer_secret_r,
                          xfer_addr_r, xfer_local_r});
         obs_b.push_back(xfer_bytes_r);
      end
      if (page_busy_r === 1'b1) busy_idx <= page_busy_idx_r;
      if (page_rel_r === 1'b1) begin
         rel_idx <= page_rel_idx_r;
         rel_sec <= page_rel_secret_r;
      end
      if (ins_done_r === 1'b1) done_cnt <= done_cnt + 1;
      if (cyc == 20000) begin
         mismatches++;
         end_sim();
      end
   end

   // Compares one word and reports a difference at once.
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Compares one observed request; an unknown secret skips that field.
   task automatic chk_req(input int i, input logic [1:0] m,
      input logic [2:0] p, input logic [31:0] a, input logic [15:0] l,
      input logic [8:0] b, input logic s);
      xrs_entry_s e;
      e = obs_q[i];
      chk("req_seen", 32'h1, {31'h0, obs_q.size() > i});
      chk("req_mode", {30'h0, m}, {30'h0, e.mode});
      chk("req_port", {29'h0, p}, {29'h0, e.port});
      chk("req_addr", a, e.addr);
      chk("req_local", {16'h0, l}, {16'h0, e.local_a});
      chk("req_bytes", {23'h0, b}, {23'h0, obs_b[i]});
      if (s !== 1'bx) chk("req_secret", {31'h0, s}, {31'h0, e.sec});
   endtask

   // IO write of one word.
   task automatic io_write(input logic [11:0] a, input logic [31:0] d);
      @(negedge sys_clk);
      io_wr = 1'b1;
      io_addr = a;
      io_wdata = d;
      @(negedge sys_clk);
      io_wr = 1'b0;
   endtask

   // IO read; the answer is taken one cycle after the strobe.
   task automatic io_read(input logic [11:0] a, output logic [31:0] d);
      @(negedge sys_clk);
      io_rd = 1'b1;
      io_addr = a;
      @(negedge sys_clk);
      io_rd = 1'b0;
      d = (io_rvalid_r === 1'b1) ? io_rdata_r : 32'hxxxxxxxx;
   endtask

   // IO read compared with an expected word.
   task automatic rd_chk(input string nm, input logic [11:0] a,
                         input logic [31:0] e);
      logic [31:0] d;
      io_read(a, d);
      chk(nm, e, d);
   endtask

   // Special register write.
   task automatic sr_set(input logic [1:0] s, input logic [31:0] d);
      @(negedge sys_clk);
      sr_wr = 1'b1;
      sr_sel = s;
      sr_wdata = d;
      @(negedge sys_clk);
      sr_wr = 1'b0;
   endtask

   // Instruction held until done, within a bounded count.
   task automatic ins(input logic [3:0] op, input logic [31:0] a,
                      input logic [31:0] b, output logic ok);
      @(negedge sys_clk);
      ins_valid = 1'b1;
      ins_subop = op;
      ins_src1 = a;
      ins_src2 = b;
      ok = 1'b0;
      for (int n = 0; n < 300 && !ok; n++) begin
         @(negedge sys_clk);
         ok = (ins_done_r === 1'b1);
      end
      ins_valid = 1'b0;
   endtask

   // Instruction that must complete.
   task automatic issue(input logic [3:0] op, input logic [31:0] a,
                        input logic [31:0] b);
      logic ok;
      ins(op, a, b, ok);
      chk("ins_done", 32'h1, {31'h0, ok});
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic end_sim();
      $display("Checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Main sequence.
   initial begin
      logic [31:0] d;
      logic        ok;
      int          n0;
      {sys_rst, io_wr, io_rd, sr_wr, ins_valid, stall} = 6'b100001;
      {io_addr, io_wdata, sr_sel, sr_wdata, cauth} = '0;
      {ins_subop, ins_src1, ins_src2} = '0;
      {mismatches, samples_checked} = '0;
      repeat (6) @(posedge sys_clk);
      @(negedge sys_clk) sys_rst = 1'b0;
      rd_chk("status", XRS_OFF_STAT, 32'h0);
      rd_chk("ctrl", XRS_OFF_CTRL, 32'h0);
      rd_chk("unmapped", 12'h124, 32'h0);
      sr_set(XRS_SR_DBASE, 32'h1234);
      sr_set(XRS_SR_CBASE, 32'h56);
      sr_set(XRS_SR_TGTS, 32'h6503);
      cauth = 32'h0001_0000;
      // Data pending only: the code wait must still release the core.
      issue(XRS_OP_DLD, 32'h40, 32'h0002_0200);
      issue(XRS_OP_CWAIT, 32'h0, 32'h0);
      issue(XRS_OP_CLD, 32'h80, 32'h0007_0300);
      issue(XRS_OP_DST, 32'h100, 32'h0006_0400);
      rd_chk("status", XRS_OFF_STAT, 32'h0101_0002);
      chk("busy_page", 32'h3, {24'h0, busy_idx});
      // The data wait is held while the port stalls.
      n0 = done_cnt;
      fork
         ins(XRS_OP_DWAIT, 32'h0, 32'h0, ok);
         begin
            repeat (30) @(negedge sys_clk);
            chk("wait_held", 32'(n0), 32'(done_cnt));
            stall = 1'b0;
         end
      join
      chk("dwait_done", 32'h1, {31'h0, ok});
      issue(XRS_OP_CWAIT, 32'h0, 32'h0);
      rd_chk("status", XRS_OFF_STAT, 32'h0);
      chk_req(0, 2'h0, 3'h5, 32'h0012_3440, 16'h0200, 9'h010, 1'bx);
      chk_req(1, 2'h1, 3'h3, 32'h0000_5680, 16'h0300, 9'h100, 1'b1);
      chk_req(2, 2'h2, 3'h6, 32'h0012_3500, 16'h0400, 9'h100, 1'bx);
      chk("rel_page", 32'h3, {24'h0, rel_idx});
      chk("rel_secret", 32'h1, {31'h0, rel_sec});
      io_write(XRS_OFF_EBASE, 32'h10);
      io_write(XRS_OFF_LADDR, 32'h0800);
      io_write(XRS_OFF_EOFF, 32'h20);
      rd_chk("ebase", XRS_OFF_EBASE, 32'h10);
      rd_chk("laddr", XRS_OFF_LADDR, 32'h0800);
      rd_chk("eoff", XRS_OFF_EOFF, 32'h20);
      // Fill the queue and the output stage so the launch must wait.
      stall = 1'b1;
      for (int i = 0; i < 5; i++) begin
         issue(XRS_OP_DLD, 32'(i * 4), 32'(i * 16));
      end
      io_write(XRS_OFF_CTRL, 32'h0000_2326);
      rd_chk("ctrl_pend", XRS_OFF_CTRL, 32'h0000_2325);
      rd_chk("status", XRS_OFF_STAT, 32'h0500_0002);
      stall = 1'b0;
      // no rewrite
      // The control register is left alone until everything drains.
      for (int n = 0; n < 100; n++) begin
         io_read(XRS_OFF_STAT, d);
         if (d === 32'h0) break;
      end
      chk("drained", 32'h0, d);
      rd_chk("ctrl", XRS_OFF_CTRL, 32'h0000_2324);
      // Only bits 4-5 of the status word take a write; counts stay zero.
      io_write(XRS_OFF_STAT, 32'hffff_ffff);
      rd_chk("stat_rw", XRS_OFF_STAT, 32'h0000_0030);
      chk_req(8, 2'h2, 3'h2, 32'h0000_1020, 16'h0800, 9'h020, 1'b1);
      end_sim();
   end
endmodule
